// ---- core/pkt_link_pkg.sv ----
// Constants, carrier types and checksum step shared by the packet link core.
// How it works
// [RQ1] Packet opens with type byte, then length
// [RQ2] Length byte counts payload, locates check field
// [RQ3] Payload count stays within 0 to 22
// [RQ4] Each type has own payload length, layout
// [RQ5] 16-bit check over type, length, payload
// [RQ6] Check sent low byte, then high byte
// [RQ7] Check follows last used payload byte directly
// [RQ8] Host awaits acknowledgement before next packet
// [RQ9] After errors, discard and resync on valid packet
// [RQ10] Answer type keeps command's low six bits
// [RQ11] Answer every packet within 250 ms
// [RQ12] Host retries unanswered packets, then reports
// [RQ13] Bad check or length: drop silently
// [RQ14] All framing bytes treated as unsigned
package pkt_link_pkg;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Framing constants
  // ----------------------------------------------------------------
  localparam int BYTE_W = 8;              // Every framing byte is unsigned 8 bit
  localparam int MAX_LEN = 22;            // Largest payload count
  localparam int IDX_W = 5;               // Holds 0..MAX_LEN
  localparam int LOW_TYPE_W = 6;          // Type bits echoed in the answer
  localparam logic [1:0] CODE_RESPONSE = 2'h1; // Upper type bits of a normal answer
  localparam logic [1:0] CODE_ERROR = 2'h2;    // Upper type bits of an error answer

  // ----------------------------------------------------------------
  // Check field: reflected 16-bit CRC, inverted at the end
  // ----------------------------------------------------------------
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_XOR = 16'hffff;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ = 200000000;  // System clock rate
  localparam longint RESP_TIME_MS = 250;  // Longest wait before answering
  // Longest time, so round down
  localparam int RESP_CYCLES = int'((CLK_HZ * RESP_TIME_MS) / 1000);

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [BYTE_W-1:0] kind;  // Type byte
    logic [BYTE_W-1:0] len;   // Payload count
  } pkt_hdr_t;

  typedef logic [MAX_LEN*BYTE_W-1:0] payload_t;  // Byte 0 in the low lane

  // One byte through the check register, least significant bit first
  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

endpackage

// ---- core/crc_packet_host_link.sv ----
// Packet receiver, answer framer and two-entry output buffer of the host link.
module crc_packet_host_link #(
  parameter int RESP_LIMIT = pkt_link_pkg::RESP_CYCLES  // Cycles before an automatic error answer
) (
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  // Byte stream from the host (same clock domain, no synchroniser needed)
  input wire logic [7:0] RX_DATA_IN,
  input wire logic RX_VALID_IN,
  output logic RX_READY_OUT,
  // Checked command towards the device logic
  output logic CMD_VALID_OUT,
  output pkt_link_pkg::pkt_hdr_t CMD_HDR_OUT,
  output pkt_link_pkg::payload_t CMD_DATA_OUT,
  // Answer from the device logic, taken while CMD_VALID_OUT is high
  input wire logic RSP_VALID_IN,
  input wire logic RSP_ERROR_IN,
  input wire logic [7:0] RSP_LEN_IN,
  input wire pkt_link_pkg::payload_t RSP_DATA_IN,
  // Byte stream towards the host
  output logic [7:0] TX_DATA_OUT,
  output logic TX_VALID_OUT,
  input wire logic TX_READY_IN
);
  timeunit 1ns;
  timeprecision 1ps;
  import pkt_link_pkg::*;

  // Refuse a limit that the response timer cannot count to
  if (RESP_LIMIT < 1) begin : g_bad_limit
    $error("RESP_LIMIT must be at least one cycle");
  end

  // ----------------------------------------------------------------
  // Receive side
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {R_TYPE, R_LEN, R_DATA, R_CRC_LO, R_CRC_HI, R_HOLD} rx_state_t;

  rx_state_t rx_state;       // Where in the packet we are
  rx_state_t next_rx_state;  // Decoded next position
  logic [IDX_W-1:0] rx_idx;  // Payload byte counter
  logic [15:0] rx_crc;       // Running check
  logic [7:0] rx_crc_lo;     // Low check byte received
  logic rx_take;             // A byte is accepted this cycle
  logic answer_take;         // Answer leaves the hold this cycle
  logic timeout;             // No answer in time

  assign rx_take = RX_VALID_IN && RX_READY_OUT;

  // Next receive position
  always_comb begin
    next_rx_state = rx_state;
    unique case (rx_state)
      R_TYPE: if (rx_take) next_rx_state = R_LEN;  // see [RQ1]
      R_LEN: begin
        if (rx_take) begin
          // Oversized count: drop, this byte may open a real packet
          if (RX_DATA_IN > 8'(MAX_LEN)) next_rx_state = R_LEN;  // see [RQ3] see [RQ13] see [RQ9]
          else if (RX_DATA_IN == 8'h00) next_rx_state = R_CRC_LO;  // see [RQ7]
          else next_rx_state = R_DATA;  // see [RQ2]
        end
      end
      R_DATA: if (rx_take && (8'(rx_idx) + 8'h01 == CMD_HDR_OUT.len)) next_rx_state = R_CRC_LO;  // see [RQ2]
      R_CRC_LO: if (rx_take) next_rx_state = R_CRC_HI;  // see [RQ6]
      R_CRC_HI: begin
        if (rx_take) begin
          // Mismatch is dropped without any answer
          if ({RX_DATA_IN, rx_crc_lo} == (rx_crc ^ CRC_XOR)) next_rx_state = R_HOLD;  // see [RQ5] see [RQ6]
          else next_rx_state = R_TYPE;  // see [RQ13] see [RQ9]
        end
      end
      R_HOLD: if (answer_take) next_rx_state = R_TYPE;
    endcase
  end

  // State and ready; ready drops while a command awaits its answer
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      rx_state <= R_TYPE;
      RX_READY_OUT <= 1'b0;
    end else begin
      rx_state <= next_rx_state;
      RX_READY_OUT <= (next_rx_state != R_HOLD);
    end
  end

  // Header, payload and check capture; bytes kept unsigned throughout
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      CMD_HDR_OUT <= '0;
      CMD_DATA_OUT <= '0;
      rx_idx <= '0;
      rx_crc <= CRC_INIT;
      rx_crc_lo <= 8'h00;
    end else if (rx_take) begin  // see [RQ14]
      unique case (rx_state)
        R_TYPE: begin
          CMD_HDR_OUT.kind <= RX_DATA_IN;  // see [RQ1]
          rx_crc <= crc_step(CRC_INIT, RX_DATA_IN);  // see [RQ5]
        end
        R_LEN: begin
          rx_idx <= '0;
          if (RX_DATA_IN > 8'(MAX_LEN)) begin
            // Resync: the rejected count is tried as a type byte
            CMD_HDR_OUT.kind <= RX_DATA_IN;  // see [RQ9]
            rx_crc <= crc_step(CRC_INIT, RX_DATA_IN);
          end else begin
            CMD_HDR_OUT.len <= RX_DATA_IN;  // see [RQ2]
            rx_crc <= crc_step(rx_crc, RX_DATA_IN);  // see [RQ5]
          end
        end
        R_DATA: begin
          CMD_DATA_OUT[rx_idx*BYTE_W +: BYTE_W] <= RX_DATA_IN;
          rx_idx <= rx_idx + 5'h01;
          rx_crc <= crc_step(rx_crc, RX_DATA_IN);  // see [RQ5]
        end
        R_CRC_LO: rx_crc_lo <= RX_DATA_IN;  // see [RQ6]
        default: ;  // High check byte is compared, not stored
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Answer handshake and response timer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {T_IDLE, T_TYPE, T_LEN, T_DATA, T_CRC_LO, T_CRC_HI} tx_state_t;

  tx_state_t tx_state;   // Framer position
  logic [31:0] timer;    // Cycles spent waiting for the answer

  assign timeout = (timer >= 32'(RESP_LIMIT - 1));
  assign answer_take = CMD_VALID_OUT && (RSP_VALID_IN || timeout);

  // Command offered only once the framer is free, so an answer is always taken at once
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      CMD_VALID_OUT <= 1'b0;
    end else if (answer_take) begin
      CMD_VALID_OUT <= 1'b0;
    end else if (rx_state == R_HOLD && tx_state == T_IDLE) begin
      CMD_VALID_OUT <= 1'b1;  // see [RQ10]
    end
  end

  // Wait counter; at its end the core answers with an error itself
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      timer <= '0;
    end else if (rx_state != R_HOLD || answer_take) begin
      timer <= '0;
    end else begin
      timer <= timer + 32'h1;  // see [RQ11]
    end
  end

  // ----------------------------------------------------------------
  // Answer framer
  // ----------------------------------------------------------------
  pkt_hdr_t tx_hdr;          // Answer header
  payload_t tx_data;         // Answer payload
  logic [IDX_W-1:0] tx_idx;  // Payload byte counter
  logic [15:0] tx_crc;       // Running check of sent bytes
  logic [7:0] push_data;     // Byte offered to the buffer
  logic push;                // Byte enters the buffer
  logic buf_ready;           // Buffer has room

  // Byte chosen by framer position
  always_comb begin
    push_data = 8'h00;
    unique case (tx_state)
      T_TYPE: push_data = tx_hdr.kind;
      T_LEN: push_data = tx_hdr.len;
      T_DATA: push_data = tx_data[tx_idx*BYTE_W +: BYTE_W];
      T_CRC_LO: push_data = tx_crc[7:0] ^ CRC_XOR[7:0];  // see [RQ6]
      T_CRC_HI: push_data = tx_crc[15:8] ^ CRC_XOR[15:8];  // see [RQ6]
      T_IDLE: push_data = 8'h00;
    endcase
  end

  assign push = (tx_state != T_IDLE) && buf_ready;

  // Framer sequence; stalls while the buffer is full
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      tx_state <= T_IDLE;
      tx_hdr <= '0;
      tx_data <= '0;
      tx_idx <= '0;
      tx_crc <= CRC_INIT;
    end else if (answer_take) begin
      tx_state <= T_TYPE;
      tx_idx <= '0;
      tx_crc <= CRC_INIT;
      if (RSP_VALID_IN) begin
        // Upper bits mark answer kind, low bits echo the command
        tx_hdr.kind <= {RSP_ERROR_IN ? CODE_ERROR : CODE_RESPONSE, CMD_HDR_OUT.kind[LOW_TYPE_W-1:0]};  // see [RQ10]
        tx_hdr.len <= (RSP_LEN_IN > 8'(MAX_LEN)) ? 8'(MAX_LEN) : RSP_LEN_IN;  // see [RQ3] see [RQ4]
        tx_data <= RSP_DATA_IN;
      end else begin
        // Late answer replaced by an empty error packet
        tx_hdr.kind <= {CODE_ERROR, CMD_HDR_OUT.kind[LOW_TYPE_W-1:0]};  // see [RQ10] see [RQ11]
        tx_hdr.len <= 8'h00;
      end
    end else if (push) begin
      unique case (tx_state)
        T_TYPE: tx_state <= T_LEN;  // see [RQ1]
        T_LEN: tx_state <= (tx_hdr.len == 8'h00) ? T_CRC_LO : T_DATA;  // see [RQ7]
        T_DATA: begin
          tx_idx <= tx_idx + 5'h01;
          if (8'(tx_idx) + 8'h01 == tx_hdr.len) tx_state <= T_CRC_LO;  // see [RQ7]
        end
        T_CRC_LO: tx_state <= T_CRC_HI;
        T_CRC_HI: tx_state <= T_IDLE;
        T_IDLE: tx_state <= T_IDLE;
      endcase
      if (tx_state == T_TYPE || tx_state == T_LEN || tx_state == T_DATA) begin
        tx_crc <= crc_step(tx_crc, push_data);  // see [RQ5]
      end
    end
  end

  // ----------------------------------------------------------------
  // Two-entry output buffer; head feeds the port straight from flops
  // ----------------------------------------------------------------
  logic [7:0] spare_data;  // Second entry
  logic spare_valid;       // Second entry in use
  logic pop;               // Host takes the head

  assign pop = TX_VALID_OUT && TX_READY_IN;
  // Room only while the spare is empty, so a host stall halts the framer
  assign buf_ready = !spare_valid;

  // Head and spare; a stall by the host loses no byte
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      TX_DATA_OUT <= 8'h00;
      TX_VALID_OUT <= 1'b0;
      spare_data <= 8'h00;
      spare_valid <= 1'b0;
    end else begin
      if (pop || !TX_VALID_OUT) begin
        // Head refills from spare first to keep byte order
        if (spare_valid) begin
          TX_DATA_OUT <= spare_data;
          TX_VALID_OUT <= 1'b1;
          spare_valid <= push;
          spare_data <= push_data;
        end else begin
          TX_DATA_OUT <= push_data;
          TX_VALID_OUT <= push;
        end
      end else if (push) begin
        spare_data <= push_data;
        spare_valid <= 1'b1;
      end
    end
  end

endmodule // crc_packet_host_link

// ---- dv/pkt_link_checker.sv ----
// Port-level assertions for the packet link core.
module pkt_link_checker #(
  parameter int RESP_LIMIT = 200  // Longest hold before the core answers itself
) (
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic RX_READY_OUT,
  input wire logic CMD_VALID_OUT,
  input wire pkt_link_pkg::pkt_hdr_t CMD_HDR_OUT,
  input wire logic RSP_VALID_IN,
  input wire logic RSP_ERROR_IN,
  input wire logic [7:0] TX_DATA_OUT,
  input wire logic TX_VALID_OUT,
  input wire logic TX_READY_IN
);
  timeunit 1ns;
  timeprecision 1ps;
  import pkt_link_pkg::*;
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  int hold_cnt;  // Cycles a command has waited, too long for a repetition
  // Count the wait so a missed timeout shows up
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN || !CMD_VALID_OUT) begin
      hold_cnt <= 0;
    end else begin
      hold_cnt <= hold_cnt + 1;
    end
  end
  sequence s_take;  // Answer taken
    CMD_VALID_OUT && RSP_VALID_IN;
  endsequence
  sequence s_take_idle;  // Answer taken while the output side is empty
    CMD_VALID_OUT && RSP_VALID_IN && !TX_VALID_OUT;
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_reset_quiet: assert property (disable iff (1'b0) !RST_N_IN |=>
    !CMD_VALID_OUT && !TX_VALID_OUT && !RX_READY_OUT)
    else $error("outputs active after reset");
  a_hold_ready: assert property (CMD_VALID_OUT |-> !RX_READY_OUT)
    else $error("bytes accepted while a command waits");
  a_answer_drop: assert property (s_take |=> !CMD_VALID_OUT)
    else $error("command stays after its answer");
  a_answer_type: assert property (s_take_idle |-> ##2 TX_VALID_OUT &&
    TX_DATA_OUT == {$past(RSP_ERROR_IN, 2) ? CODE_ERROR : CODE_RESPONSE, $past(CMD_HDR_OUT[13:8], 2)})
    else $error("answer type byte wrong");
  a_tx_hold: assert property (TX_VALID_OUT && !TX_READY_IN |=> TX_VALID_OUT && $stable(TX_DATA_OUT))
    else $error("output byte lost during stall");
  a_answer_bound: assert property (hold_cnt <= RESP_LIMIT + 1)
    else $error("command waited past the answer limit");
  a_ready_after: assert property ($fell(CMD_VALID_OUT) |-> RX_READY_OUT)
    else $error("receiver not reopened after answer");
  a_len_range: assert property (CMD_VALID_OUT |-> CMD_HDR_OUT.len <= MAX_LEN)
    else $error("command length out of range");
  a_hdr_stable: assert property (CMD_VALID_OUT && $past(CMD_VALID_OUT) |-> $stable(CMD_HDR_OUT))
    else $error("command header changed while held");
endmodule // pkt_link_checker

bind crc_packet_host_link pkt_link_checker #(.RESP_LIMIT(RESP_LIMIT)) pkt_link_checker_i (
  .SYS_CLK_IN(SYS_CLK_IN), .RST_N_IN(RST_N_IN), .RX_READY_OUT(RX_READY_OUT),
  .CMD_VALID_OUT(CMD_VALID_OUT), .CMD_HDR_OUT(CMD_HDR_OUT), .RSP_VALID_IN(RSP_VALID_IN),
  .RSP_ERROR_IN(RSP_ERROR_IN), .TX_DATA_OUT(TX_DATA_OUT), .TX_VALID_OUT(TX_VALID_OUT),
  .TX_READY_IN(TX_READY_IN));

// ---- dv/host_model.sv ----
// Host side model: sends queued bytes and collects answer bytes.
module host_model (
  input wire logic clk_in,
  input wire logic [1:0] mode_in,  // 0 ready, 1 toggling, 2 stalled
  input wire logic rx_ready_in,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_valid_in,
  output logic [7:0] rx_data_out,
  output logic rx_valid_out,
  output logic tx_ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rxq[$];  // Bytes still to send
  logic [7:0] got[$];  // Bytes taken from the core
  logic phase;  // Drives the toggling acceptance pattern
  initial begin
    rx_data_out = 8'h00;
    rx_valid_out = 1'b0;
    tx_ready_out = 1'b0;
    phase = 1'b0;
  end
  // Byte pump; an idle line shows the inverse so no stale byte looks valid
  always @(posedge clk_in) begin
    if (rx_valid_out && rx_ready_in) begin
      void'(rxq.pop_front());  // Bytes leave strictly in order
    end
    rx_valid_out <= (rxq.size() != 0);
    rx_data_out <= (rxq.size() != 0) ? rxq[0] : ~rx_data_out;
    if (tx_valid_in && tx_ready_out) begin
      got.push_back(tx_data_in);
    end
    phase <= ~phase;
    tx_ready_out <= (mode_in == 2'h0) || ((mode_in == 2'h1) && phase);
  end
endmodule // host_model

// ---- dv/crc_packet_host_link_tb_top.sv ----
// Self-checking bench for the packet link core.
module crc_packet_host_link_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pkt_link_pkg::*;
  localparam int LIMIT = 200;  // Short answer timeout keeps the run brief
  typedef struct packed {logic [7:0] kind; logic [7:0] len; logic [7:0] err; logic [7:0] rlen;} row_t;
  // Ordinary commands: type, length, error answer, answer length (last one clamps)
  localparam row_t ROWS [4] = '{'{8'h00, 8'h00, 8'h00, 8'h00}, '{8'h01, 8'h10, 8'h01, 8'h16},
    '{8'hc2, 8'h16, 8'h00, 8'h03}, '{8'h3f, 8'h05, 8'h01, 8'h20}};
  logic clk, rst_n, rsp_valid, rsp_error, seen;
  logic [7:0] rsp_len;
  logic [1:0] mode;  // Host acceptance pattern
  logic [7:0] q[$];  // Packet being built
  payload_t rsp_data, cmd_data;
  pkt_hdr_t hdr;
  wire logic [7:0] rx_data, tx_data;
  wire logic rx_valid, rx_ready, tx_valid, tx_ready, cmd_valid;
  int errors, comparisons;
  crc_packet_host_link #(.RESP_LIMIT(LIMIT)) crc_packet_host_link_i (
    .SYS_CLK_IN(clk), .RST_N_IN(rst_n), .RX_DATA_IN(rx_data), .RX_VALID_IN(rx_valid),
    .RX_READY_OUT(rx_ready), .CMD_VALID_OUT(cmd_valid), .CMD_HDR_OUT(hdr), .CMD_DATA_OUT(cmd_data),
    .RSP_VALID_IN(rsp_valid), .RSP_ERROR_IN(rsp_error), .RSP_LEN_IN(rsp_len), .RSP_DATA_IN(rsp_data),
    .TX_DATA_OUT(tx_data), .TX_VALID_OUT(tx_valid), .TX_READY_IN(tx_ready));
  host_model host_model_i (.clk_in(clk), .mode_in(mode), .rx_ready_in(rx_ready), .tx_data_in(tx_data),
    .tx_valid_in(tx_valid), .rx_data_out(rx_data), .rx_valid_out(rx_valid), .tx_ready_out(tx_ready));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c ^ CRC_XOR;
  endfunction
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Queue a packet with its check, low byte first; bad spoils the check
  task automatic send_pkt(input logic [7:0] b[$], input logic bad);
    logic [15:0] c;
    c = crc16(b);
    foreach (b[i]) host_model_i.rxq.push_back(b[i]);
    host_model_i.rxq.push_back(c[7:0] ^ {7'h00, bad});
    host_model_i.rxq.push_back(c[15:8]);
  endtask
  task automatic wait_cmd(input int n);
    seen = 1'b0;
    for (int i = 0; i < n && !seen; i++) begin
      @(posedge clk);
      seen = (cmd_valid === 1'b1);
    end
  endtask
  // Wait for a whole answer frame, then compare it byte by byte
  task automatic check_frame(input logic [7:0] kind, input logic [7:0] len, input int n);
    logic [7:0] e[$];
    logic [15:0] c;
    e = {kind, len};
    for (int i = 0; i < int'(len); i++) e.push_back(8'ha0 + i[7:0]);
    c = crc16(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    for (int i = 0; i < n && host_model_i.got.size() < e.size(); i++) @(posedge clk);
    if (host_model_i.got.size() < e.size()) begin
      // Frame never completed: count it and go straight to the verdict
      errors++;
      $display("BAD %0t answer frame incomplete", $time);
      summarize();
    end else begin
      foreach (e[i]) cmp8(host_model_i.got[i], e[i]);
      host_model_i.got.delete();
    end
  endtask
  // Send, see the command, answer it, optionally hold a host stall then lift it, check the frame
  task automatic exchange(input logic [7:0] p[$], input logic [7:0] err, input logic [7:0] rlen, input int hold);
    send_pkt(p, 1'b0);
    wait_cmd(200);
    cmp8({7'h00, seen}, 8'h01);
    cmp8(hdr.kind, p[0]);
    cmp8(hdr.len, p[1]);
    for (int i = 0; i < int'(p[1]); i++) cmp8(cmd_data[8*i +: 8], p[i+2]);
    rsp_valid <= 1'b1;
    rsp_error <= err[0];
    rsp_len <= rlen;
    @(posedge clk);
    rsp_valid <= 1'b0;
    repeat (hold) @(posedge clk);
    // Only a deliberate stall is lifted, so toggling rows keep pacing the answer
    if (hold > 0) begin
      cmp8(8'(host_model_i.got.size()), 8'h00);
      mode <= 2'h0;
    end
    check_frame({err[0] ? CODE_ERROR : CODE_RESPONSE, p[0][5:0]}, (rlen > 8'h16) ? 8'h16 : rlen, 400);
  endtask
  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    {rst_n, rsp_valid, rsp_error, rsp_len, mode, errors, comparisons} = '0;
    for (int i = 0; i < MAX_LEN; i++) rsp_data[8*i +: 8] = 8'ha0 + i[7:0];
    repeat (4) @(posedge clk);
    cmp8({5'h00, rx_ready, cmd_valid, tx_valid}, 8'h00);
    rst_n <= 1'b1;
    foreach (ROWS[r]) begin  // Odd rows stall the host every other cycle
      mode <= {1'b0, r[0]};
      q = {ROWS[r].kind, ROWS[r].len};
      for (int i = 0; i < int'(ROWS[r].len); i++) q.push_back(ROWS[r].kind + i[7:0]);
      exchange(q, ROWS[r].err, ROWS[r].rlen, 0);
      $display("row %0d done", r);
    end
    send_pkt({8'h07, 8'h01, 8'h33}, 1'b1);  // Spoiled check is dropped
    wait_cmd(40);
    cmp8({7'h00, seen}, 8'h00);
    // No answer in time, so the host sends the same packet again
    exchange({8'h07, 8'h01, 8'h33}, 8'h00, 8'h01, 0);
    $display("bad check done");
    host_model_i.rxq.push_back(8'h05);  // Length 0x17 is refused and reused as type
    exchange({8'h17, 8'h00}, 8'h00, 8'h00, 0);
    $display("bad length done");
    send_pkt({8'h25, 8'h00}, 1'b0);  // Unanswered command
    wait_cmd(200);
    cmp8({7'h00, seen}, 8'h01);
    check_frame({CODE_ERROR, 6'h25}, 8'h00, LIMIT + 50);
    $display("timeout done");
    mode <= 2'h2;  // Host stalls while a full answer is framed
    exchange({8'h11, 8'h00}, 8'h00, 8'h16, 40);
    $display("stall done");
    send_pkt({8'h3a, 8'h00}, 1'b0);
    wait_cmd(200);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    cmp8({6'h00, cmd_valid, tx_valid}, 8'h00);
    rst_n <= 1'b1;
    exchange({8'h3b, 8'h02, 8'h01, 8'h02}, 8'h01, 8'h00, 0);
    $display("reset done");
    summarize();
  end
endmodule // crc_packet_host_link_tb_top
